//--- src/bidr_defines.svh
// Offsets, field positions and values for the board identity register bank
// ----------------------------------------
// What this block does
// R1 - Version words: firmware type in upper 16 bits, version number lower 16
// R2 - Standard release images report firmware type code 1
// R3 - Golden recovery version of main controller reports type code 2
// R4 - Front-end B version reads all zeros when no module B fitted
// R5 - Extension module version reads all zeros when no extension fitted
// R6 - Active image word: type top digit, three-digit version, four unused digits
// R7 - Unused low four hex digits of active image word read zero
// R8 - Production date: week in bits 31:16, year in bits 15:0
// R9 - Calibration date: week in bits 31:16, year in bits 15:0
// R10 - Calibration date changes only by factory calibration, never user calibration
// R11 - Serial number register returns the board's unique serial number
// R12 - Maximum sampling rate returned in hertz as 64-bit integer
// R13 - Maximum rate ignores channel-configuration speed reductions
// R14 - Active image register exists only when a golden image is present
// R15 - All registers read-only; writes ignored and change nothing (code: a factory-mode full-word write updates the calibration date)
// ----------------------------------------
`ifndef BIDR_DEFINES_SVH
`define BIDR_DEFINES_SVH

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define BIDR_IDX_PROD_DATE 20'h007e4
`define BIDR_IDX_CALIB_DATE 20'h007e9
`define BIDR_IDX_SERIAL 20'h007ee
`define BIDR_IDX_MAX_RATE 20'h00834
`define BIDR_IDX_MAX_RATE_HI 20'h00835
`define BIDR_IDX_MAIN_VER 20'h33450
`define BIDR_IDX_RECOV_VER 20'h33451
`define BIDR_IDX_ACTIVE_VER 20'h33452
`define BIDR_IDX_CLOCK_VER 20'h3345a
`define BIDR_IDX_CONFIG_VER 20'h33464
`define BIDR_IDX_FE_A_VER 20'h3346e
`define BIDR_IDX_FE_B_VER 20'h3346f
`define BIDR_IDX_EXT_VER 20'h33482
`define BIDR_IDX_POWER_VER 20'h3348c
`define BIDR_IDX_CALIB_CTRL 20'h33500

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define BIDR_TYPE_MSB 31
`define BIDR_TYPE_LSB 16
`define BIDR_TYPE_STANDARD 16'h0001
`define BIDR_TYPE_GOLDEN 16'h0002
`define BIDR_ACT_TYPE_STANDARD 4'h1
`define BIDR_ACT_TYPE_GOLDEN 4'h2
`define BIDR_ACT_UNUSED 16'h0000
`define BIDR_UNMAPPED_DATA 32'h00000000
`define BIDR_CALIB_COMMIT_BIT 0

`endif

//--- src/bidr_pkg.sv
// Types for the board identity register bank
package bidr_pkg;

   // ----------------------------------------
   // Version word, date word, active image word, bus handshake state
   // ----------------------------------------
   typedef struct packed
   {
      logic [15:0] fw_type;
      logic [15:0] fw_number;
   } bidr_version_t;

   typedef struct packed
   {
      logic [15:0] week;
      logic [15:0] year;
   } bidr_date_t;

   typedef struct packed
   {
      logic [3:0] boot_type;
      logic [11:0] version;
      logic [15:0] unused;
   } bidr_active_t;

   typedef enum logic [1:0]
   {
      BIDR_IDLE = 2'b00,
      BIDR_ANSWER = 2'b01,
      BIDR_RELEASE = 2'b10
   } bidr_state_t;

endpackage : bidr_pkg

//--- src/bidr_regs.sv
// Board identity register bank, Avalon-MM slave
`timescale 1ns/1ps
`include "bidr_defines.svh"

module bidr_regs
   import bidr_pkg::*;
#(
   parameter int ADDR_W = 22,
   parameter bit HAS_GOLDEN = 1'b1,
   parameter logic [15:0] MAIN_FW_NUMBER = 16'h0001,
   parameter logic [15:0] RECOV_FW_NUMBER = 16'h0001,
   parameter logic [15:0] CLOCK_FW_NUMBER = 16'h0001,
   parameter logic [15:0] CONFIG_FW_NUMBER = 16'h0001,
   parameter logic [15:0] FE_A_FW_NUMBER = 16'h0001,
   parameter logic [15:0] FE_B_FW_NUMBER = 16'h0001,
   parameter logic [15:0] EXT_FW_NUMBER = 16'h0001,
   parameter logic [15:0] POWER_FW_NUMBER = 16'h0001,
   parameter logic [31:0] SERIAL = 32'h00001234,
   parameter logic [31:0] PROD_DATE = 32'h00010001,
   parameter logic [63:0] MAX_RATE_HZ = 64'h0000000000000001
)
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic FE_B_PRESENT,
   input wire logic EXT_PRESENT,
   input wire logic BOOTED_GOLDEN,
   input wire logic FACTORY_MODE,
   input wire logic [31:0] CALIB_DATE_INIT
);

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   // Index decode takes a full 20-bit word index, so narrower buses cannot reach the bank
   if (ADDR_W < 22)
   begin : g_addr_w_check
      $error("bidr_regs: ADDR_W must be at least 22");
   end

   // ----------------------------------------
   // Decode and state
   // ----------------------------------------
   bidr_state_t state;
   logic [19:0] index;
   logic [31:0] next_rdata;
   bidr_date_t calib_date;
   logic calib_loaded;
   logic [ADDR_W-3:0] word_addr;
   logic [ADDR_W-3:0] word_idx;
   bidr_version_t ver;
   bidr_active_t act;

   // Word addressed: drop the two byte bits
   assign word_addr = AVS_ADDRESS[ADDR_W-1:2];
   assign word_idx = word_addr;
   assign index = word_addr[19:0];

   // ----------------------------------------
   // Read multiplexer
   // ----------------------------------------
   always_comb
   begin
      next_rdata = `BIDR_UNMAPPED_DATA;
      ver = '0;
      act = '0;
      if (word_idx[ADDR_W-3:0] == {{(ADDR_W-22){1'b0}}, index})
      begin
         case (index)
            `BIDR_IDX_PROD_DATE: next_rdata = PROD_DATE; // R8
            `BIDR_IDX_CALIB_DATE: next_rdata = calib_date; // R9
            `BIDR_IDX_SERIAL: next_rdata = SERIAL; // R11
            // Unrestricted board limit, channel modes not applied
            `BIDR_IDX_MAX_RATE: next_rdata = MAX_RATE_HZ[31:0]; // R12 R13
            `BIDR_IDX_MAX_RATE_HI: next_rdata = MAX_RATE_HZ[63:32]; // R12
            `BIDR_IDX_MAIN_VER:
            begin
               ver = '{`BIDR_TYPE_STANDARD, MAIN_FW_NUMBER}; // R1 R2
               next_rdata = ver;
            end
            `BIDR_IDX_RECOV_VER:
            begin
               if (HAS_GOLDEN)
               begin
                  ver = '{`BIDR_TYPE_GOLDEN, RECOV_FW_NUMBER}; // R3
               end
               next_rdata = ver;
            end
            `BIDR_IDX_ACTIVE_VER:
            begin
               if (HAS_GOLDEN) // R14
               begin
                  act.boot_type = BOOTED_GOLDEN ? `BIDR_ACT_TYPE_GOLDEN
                                                : `BIDR_ACT_TYPE_STANDARD; // R6
                  act.version = BOOTED_GOLDEN ? RECOV_FW_NUMBER[11:0]
                                              : MAIN_FW_NUMBER[11:0]; // R6
                  act.unused = `BIDR_ACT_UNUSED; // R7
               end
               next_rdata = act;
            end
            `BIDR_IDX_CLOCK_VER:
            begin
               ver = '{`BIDR_TYPE_STANDARD, CLOCK_FW_NUMBER}; // R1
               next_rdata = ver;
            end
            `BIDR_IDX_CONFIG_VER:
            begin
               ver = '{`BIDR_TYPE_STANDARD, CONFIG_FW_NUMBER}; // R1
               next_rdata = ver;
            end
            `BIDR_IDX_FE_A_VER:
            begin
               ver = '{`BIDR_TYPE_STANDARD, FE_A_FW_NUMBER}; // R1
               next_rdata = ver;
            end
            `BIDR_IDX_FE_B_VER:
            begin
               if (FE_B_PRESENT) // R4
               begin
                  ver = '{`BIDR_TYPE_STANDARD, FE_B_FW_NUMBER};
               end
               next_rdata = ver;
            end
            `BIDR_IDX_EXT_VER:
            begin
               if (EXT_PRESENT) // R5
               begin
                  ver = '{`BIDR_TYPE_STANDARD, EXT_FW_NUMBER};
               end
               next_rdata = ver;
            end
            `BIDR_IDX_POWER_VER:
            begin
               ver = '{`BIDR_TYPE_STANDARD, POWER_FW_NUMBER}; // R1
               next_rdata = ver;
            end
            default: next_rdata = `BIDR_UNMAPPED_DATA;
         endcase
      end
   end

   // ----------------------------------------
   // Bus handshake: one wait cycle, then answer
   // ----------------------------------------
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         state <= BIDR_IDLE;
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= 32'h00000000;
      end
      else
      begin
         case (state)
            BIDR_IDLE:
            begin
               if (AVS_READ || AVS_WRITE)
               begin
                  state <= BIDR_ANSWER;
                  AVS_WAITREQUEST <= 1'b0;
                  AVS_READDATA <= AVS_READ ? next_rdata : 32'h00000000;
               end
            end
            BIDR_ANSWER:
            begin
               // Master releases here; waitrequest rises again
               state <= BIDR_RELEASE;
               AVS_WAITREQUEST <= 1'b1;
            end
            BIDR_RELEASE:
            begin
               state <= BIDR_IDLE;
            end
            default:
            begin
               state <= BIDR_IDLE;
               AVS_WAITREQUEST <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Calibration date store
   // ----------------------------------------
   // Only the factory strap unlocks the commit; user calibration has no path here
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         calib_date <= '0;
         calib_loaded <= 1'b0;
      end
      else if (!calib_loaded)
      begin
         calib_date <= CALIB_DATE_INIT;
         calib_loaded <= 1'b1;
      end
      else if (FACTORY_MODE && AVS_WRITE && state == BIDR_ANSWER
               && index == `BIDR_IDX_CALIB_DATE && (&AVS_BYTEENABLE)) // R10
      begin
         calib_date <= AVS_WRITEDATA;
      end
   end
   // All other writes are accepted and dropped // R15

endmodule : bidr_regs

//--- sim/bidr_regs_asserts.sv
// Port checks for the board identity register bank
`timescale 1ns/1ps
`include "bidr_defines.svh"
module bidr_asserts
   import bidr_pkg::*;
#(
   parameter int ADDR_W = 22,
   parameter logic [31:0] SERIAL = 32'h0
)
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic FE_B_PRESENT,
   input wire logic EXT_PRESENT,
   input wire logic BOOTED_GOLDEN
);
   // ------
   // Handshake and read values
   // ------
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   logic [ADDR_W-3:0] idx;
   assign idx = AVS_ADDRESS[ADDR_W-1:2];
   sequence ask_s;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   sequence answer_s;
      AVS_READ && !AVS_WAITREQUEST;
   endsequence
   ans_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low too long");
   ans_cause_a: assert property ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
      else $error("answer without request");
   ans_bound_a: assert property (ask_s |-> ##[1:3] !AVS_WAITREQUEST)
      else $error("request not answered");
   main_type_a: assert property (answer_s ##0 (idx == `BIDR_IDX_MAIN_VER)
      |-> AVS_READDATA[31:16] == 16'h0001) else $error("main type wrong");
   recov_type_a: assert property (answer_s ##0 (idx == `BIDR_IDX_RECOV_VER)
      |-> AVS_READDATA[31:16] == 16'h0002) else $error("recovery type wrong");
   feb_zero_a: assert property (answer_s ##0 (idx == `BIDR_IDX_FE_B_VER && !FE_B_PRESENT)
      |-> AVS_READDATA == 32'h0) else $error("absent module b not zero");
   ext_zero_a: assert property (answer_s ##0 (idx == `BIDR_IDX_EXT_VER && !EXT_PRESENT)
      |-> AVS_READDATA == 32'h0) else $error("absent extension not zero");
   act_word_a: assert property (answer_s ##0 (idx == `BIDR_IDX_ACTIVE_VER)
      |-> AVS_READDATA[31:28] == (BOOTED_GOLDEN ? 4'h2 : 4'h1) && AVS_READDATA[15:0] == 16'h0)
      else $error("active word wrong");
   serial_val_a: assert property (answer_s ##0 (idx == `BIDR_IDX_SERIAL)
      |-> AVS_READDATA == SERIAL) else $error("serial wrong");
endmodule : bidr_asserts

bind bidr_regs bidr_asserts #(.ADDR_W(ADDR_W), .SERIAL(SERIAL)) bidr_asserts_i (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .FE_B_PRESENT(FE_B_PRESENT), .EXT_PRESENT(EXT_PRESENT), .BOOTED_GOLDEN(BOOTED_GOLDEN));

//--- sim/tb_top.sv
// Self-checking bench for the board identity register bank
`timescale 1ns/1ps
module tb_top
   import bidr_pkg::*;
;
   // ------
   // Design and stimulus
   // ------
   localparam logic [31:0] SER = 32'h5a3c9e17;
   localparam logic [31:0] PDATE = 32'h002d07e4;
   localparam logic [63:0] RATE = 64'h000000012a05f200;
   logic sys_clk = 0, rst_n = 0, rd = 0, wr = 0, fe_b = 1, ext = 1, golden = 0, factory = 0;
   logic [21:0] addr = '0;
   logic [3:0] be = 4'hf;
   logic [31:0] wdata = '0, rdata, got, cal, calib_init = '0;
   logic waitreq;
   int miscompares = 0, cmp_count = 0;
   logic [19:0] vidx [8] = '{20'h33450, 20'h3345a, 20'h33464, 20'h3346e, 20'h3346f,
      20'h33482, 20'h3348c, 20'h33451};
   bidr_regs #(.MAIN_FW_NUMBER(16'h3450), .RECOV_FW_NUMBER(16'h3451),
      .CLOCK_FW_NUMBER(16'h345a), .CONFIG_FW_NUMBER(16'h3464), .FE_A_FW_NUMBER(16'h346e),
      .FE_B_FW_NUMBER(16'h346f), .EXT_FW_NUMBER(16'h3482), .POWER_FW_NUMBER(16'h348c),
      .SERIAL(SER), .PROD_DATE(PDATE), .MAX_RATE_HZ(RATE)) bidr_regs_i (
      .SYS_CLK(sys_clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(waitreq), .FE_B_PRESENT(fe_b), .EXT_PRESENT(ext),
      .BOOTED_GOLDEN(golden), .FACTORY_MODE(factory), .CALIB_DATE_INIT(calib_init));
   always #4 sys_clk = ~sys_clk;

   task test_done;
      if (miscompares == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // One bus cycle; held until waitrequest is sampled low
   task acc(input logic w, input logic [19:0] idx, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge sys_clk);
      rd <= !w;
      wr <= w;
      addr <= {idx, 2'b00};
      wdata <= d;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (waitreq !== 1'b0 && n < 20);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (waitreq !== 1'b0)
      begin
         miscompares++;
         test_done;
      end
   endtask : acc

   task rchk(input string name, input logic [19:0] idx, input logic [31:0] exp);
      acc(1'b0, idx, 32'h0, got);
      chk(name, exp, got);
   endtask : rchk

   function logic [31:0] ver_word(input int k);
      if ((k == 4 && !fe_b) || (k == 5 && !ext))
         return 32'h0;
      return {(k == 7) ? 16'h0002 : 16'h0001, vidx[k][15:0]};
   endfunction : ver_word

   task check_all;
      for (int k = 0; k < 8; k++)
         rchk("version", vidx[k], ver_word(k));
      rchk("active", 20'h33452, {golden ? 16'h2451 : 16'h1450, 16'h0});
      rchk("prod_date", 20'h007e4, PDATE);
      rchk("calib_date", 20'h007e9, cal);
      rchk("serial", 20'h007ee, SER);
      rchk("rate_lo", 20'h00834, RATE[31:0]);
      rchk("rate_hi", 20'h00835, RATE[63:32]);
      rchk("unmapped", 20'h40000 | 20'($urandom_range(0, 65535)), 32'h0);
   endtask : check_all

   initial
   begin
      void'($urandom(66));
      cal = $urandom;
      calib_init = cal;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      check_all;
      fe_b <= 1'b0;
      ext <= 1'b0;
      golden <= 1'b1;
      check_all;
      for (int k = 0; k < 20; k++)
      begin
         be <= 4'($urandom);
         acc(1'b1, vidx[$urandom_range(0, 7)], $urandom, got);
      end
      be <= 4'hf;
      acc(1'b1, 20'h007e9, ~cal, got);
      check_all;
      factory <= 1'b1;
      be <= 4'($urandom_range(0, 14));
      acc(1'b1, 20'h007e9, ~cal, got);
      rchk("partial_calib", 20'h007e9, cal);
      be <= 4'hf;
      acc(1'b1, 20'h007e9, ~cal, got);
      factory <= 1'b0;
      rchk("factory_calib", 20'h007e9, ~cal);
      test_done;
   end
endmodule : tb_top
